// File: rtl/i2c_master_byte_engine.sv
// Functional notes
// - Standard 100k and fast 400k preset rates; prescale register sets any other
// - Lines only pulled low or released
// - Eight-bit bytes, one pulse per bit, MSB first
// - Receiver acknowledges on ninth clock pulse
// - Data changes only while clock low
// - Start is data falling while clock high
// - Start only when bus idle or already ours (repeated start)
// - Begin plus read/write issues start or repeated start
// - First byte holds address plus direction
// - Ten-bit address as two address bytes
// - Address sent as ordinary write
// - Busy flag during byte, done flag after
// - Receive data valid at done; wait busy clear
// - Stop is data rising while clock high
// - Lost arbitration cancels transfer, flags it
// - Four-times enable, waits on stretched clock
// - Begin, stop, read gives start-read-stop
// - Byte split into bit operations
// - Bit is idle plus four phases, stop three
// - Shift register in from line, out from holding
// - Detect start and stop, report bus busy
// - Eight-bit register access port
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_byte_engine_map.svh"

module i2c_master_byte_engine
	import i2c_byte_engine_pkg::*;
(
	// Clock and reset
	input  wire logic       I_CLK,
	input  wire logic       I_RST,
	// Register port
	input  wire logic [2:0] I_ADDR,
	input  wire logic [7:0] I_WDATA,
	input  wire logic       I_WR,
	input  wire logic       I_RD,
	output logic      [7:0] O_RDATA,
	output logic            O_IRQ,
	// Serial bus lines
	input  wire logic       I_SCL,
	output logic            O_SCL,
	output logic            O_SCL_OE,
	input  wire logic       I_SDA,
	output logic            O_SDA,
	output logic            O_SDA_OE
);

	// ======================================================================
	// Registers
	logic [15:0] prescale;
	logic [7:0]  ctrl;
	logic [7:0]  tx_hold;
	logic [7:0]  rx_data;
	logic        cmd_begin;
	logic        cmd_stop;
	logic        cmd_read;
	logic        cmd_write;
	logic        cmd_nack;
	logic        xfer_busy;
	logic        done_flag;
	logic        arb_lost;
	logic        rx_nack;
	logic        bus_busy;
	logic        finish;
	logic        lost;
	logic        enable;

	assign enable = ctrl[`CTRL_EN_BIT];

	// Start-of-day prescale gives the standard rate at the system clock
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			prescale <= 16'(`PRESC_STD);
			ctrl     <= `CTRL_RESET;
			tx_hold  <= `DATA_RESET;
		end else if (I_WR) begin
			case (I_ADDR)
				`REG_PRESC_LO: prescale[7:0]  <= I_WDATA;
				`REG_PRESC_HI: prescale[15:8] <= I_WDATA;
				`REG_CTRL:     ctrl           <= I_WDATA;
				`REG_DATA:     tx_hold        <= I_WDATA;
				default: begin
				end
			endcase
		end
	end

	// Commands are held until the byte finishes; writes while busy ignored
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			cmd_begin <= 1'b0;
			cmd_stop  <= 1'b0;
			cmd_read  <= 1'b0;
			cmd_write <= 1'b0;
			cmd_nack  <= 1'b0;
			xfer_busy <= 1'b0;
		end else if (finish || lost) begin
			cmd_begin <= 1'b0;
			cmd_stop  <= 1'b0;
			cmd_read  <= 1'b0;
			cmd_write <= 1'b0;
			xfer_busy <= 1'b0;
		end else if (I_WR && I_ADDR == `REG_CMD_STAT && !xfer_busy
				&& enable) begin
			cmd_begin <= I_WDATA[`CMD_BEGIN_BIT];
			cmd_stop  <= I_WDATA[`CMD_STOP_BIT];
			cmd_read  <= I_WDATA[`CMD_READ_BIT];
			cmd_write <= I_WDATA[`CMD_WRITE_BIT];
			cmd_nack  <= I_WDATA[`CMD_NACK_BIT];
			xfer_busy <= I_WDATA[`CMD_READ_BIT] | I_WDATA[`CMD_WRITE_BIT]
				| I_WDATA[`CMD_STOP_BIT];
		end
	end

	// Sticky flags: a set in the clearing cycle wins
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			done_flag <= 1'b0;
			arb_lost  <= 1'b0;
		end else begin
			if (finish || lost) begin
				done_flag <= 1'b1;
			end else if (I_WR && I_ADDR == `REG_CMD_STAT
					&& I_WDATA[`CMD_IACK_BIT]) begin
				done_flag <= 1'b0;
			end
			if (lost) begin
				arb_lost <= 1'b1;
			end else if (I_WR && I_ADDR == `REG_CMD_STAT
					&& I_WDATA[`CMD_IACK_BIT]) begin
				arb_lost <= 1'b0;
			end
		end
	end

	assign O_IRQ = done_flag & ctrl[`CTRL_IEN_BIT];

	// Read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_RDATA <= 8'h00;
		end else if (I_RD) begin
			case (I_ADDR)
				`REG_PRESC_LO: O_RDATA <= prescale[7:0];
				`REG_PRESC_HI: O_RDATA <= prescale[15:8];
				`REG_CTRL:     O_RDATA <= ctrl;
				`REG_DATA:     O_RDATA <= rx_data;
				`REG_CMD_STAT: O_RDATA <= {rx_nack, bus_busy, arb_lost,
					3'h0, xfer_busy, done_flag};
				default:       O_RDATA <= 8'h00;
			endcase
		end else begin
			O_RDATA <= 8'h00;
		end
	end

	// ======================================================================
	// Line synchronisers and condition detection
	line_pair_t meta;
	line_pair_t lines;
	line_pair_t lines_d;
	logic       start_seen;
	logic       stop_seen;

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			meta    <= '{scl: 1'b1, sda: 1'b1};
			lines   <= '{scl: 1'b1, sda: 1'b1};
			lines_d <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			meta    <= '{scl: I_SCL, sda: I_SDA};
			lines   <= meta;
			lines_d <= lines;
		end
	end

	assign start_seen = lines.scl & lines_d.scl & lines_d.sda & !lines.sda;
	assign stop_seen  = lines.scl & lines_d.scl & !lines_d.sda & lines.sda;

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			bus_busy <= 1'b0;
		end else if (start_seen) begin
			bus_busy <= 1'b1;
		end else if (stop_seen) begin
			bus_busy <= 1'b0;
		end
	end

	// ======================================================================
	// Phase enable at four times the bus rate
	logic [15:0] div_cnt;
	logic        phase_en;
	logic        stall;
	logic        scl_drive;
	logic        sda_drive;

	// Released clock still low means a slave is stretching it
	assign stall = !scl_drive && !lines.scl;

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			div_cnt <= 16'h0000;
		end else if (!enable || phase_en) begin
			div_cnt <= prescale;
		end else if (!stall) begin
			div_cnt <= div_cnt - 16'h0001;
		end
	end

	assign phase_en = enable && !stall && div_cnt == 16'h0000;

	// ======================================================================
	// Bit sequencer
	bit_phase_t phase;
	bit_op_t    op;
	logic       bit_go;
	bit_op_t    bit_op;
	logic       bit_din;
	logic       bit_out;
	logic       bit_done;
	logic       next_scl_drive;
	logic       next_sda_drive;
	logic       last_phase;

	assign last_phase = (op == OP_STOP) ? (phase == PH_C)
		: (phase == PH_D);

	// Lost if we release data in a write or start but it reads low while clock is high, or on a stop we did not send
	assign lost = phase != PH_IDLE && (
		(!sda_drive && !lines.sda && lines.scl
			&& ((op == OP_WRITE && (phase == PH_B || phase == PH_C))
			|| (op == OP_START && phase == PH_B)))
		|| (stop_seen && op != OP_STOP));

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			phase <= PH_IDLE;
			op    <= OP_START;
		end else if (lost || !enable) begin
			phase <= PH_IDLE;
		end else if (phase == PH_IDLE) begin
			if (bit_go) begin
				phase <= PH_A;
				op    <= bit_op;
			end
		end else if (phase_en) begin
			case (phase)
				PH_A:    phase <= PH_B;
				PH_B:    phase <= PH_C;
				PH_C:    phase <= last_phase ? PH_IDLE : PH_D;
				PH_D:    phase <= PH_IDLE;
				default: phase <= PH_IDLE;
			endcase
		end
	end

	assign bit_done = phase_en && last_phase && !lost;

	// Sample data in the middle of the clock-high window
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			bit_out <= 1'b1;
		end else if (phase == PH_C && phase_en) begin
			bit_out <= lines.sda;
		end
	end

	// Drive levels per phase; a drive bit of one pulls the line low
	always_comb begin
		next_scl_drive = scl_drive;
		next_sda_drive = sda_drive;
		case (phase)
			PH_A: begin
				case (op)
					OP_START: begin
						// Release data first for a repeated start
						next_sda_drive = 1'b0;
					end
					OP_STOP: begin
						next_scl_drive = 1'b1;
						next_sda_drive = 1'b1;
					end
					OP_WRITE: begin
						next_scl_drive = 1'b1;
						next_sda_drive = !bit_din;
					end
					default: begin
						next_scl_drive = 1'b1;
						next_sda_drive = 1'b0;
					end
				endcase
			end
			PH_B: begin
				next_scl_drive = 1'b0;
			end
			PH_C: begin
				if (op == OP_START) begin
					next_sda_drive = 1'b1;
				end else if (op == OP_STOP) begin
					next_sda_drive = 1'b0;
				end
			end
			PH_D: begin
				next_scl_drive = 1'b1;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			scl_drive <= 1'b0;
			sda_drive <= 1'b0;
		end else if (lost || !enable) begin
			scl_drive <= 1'b0;
			sda_drive <= 1'b0;
		end else if (phase == PH_A && bit_go == 1'b0 && !phase_en) begin
			// Hold phase A settings steady until the phase ends
			scl_drive <= next_scl_drive;
			sda_drive <= next_sda_drive;
		end else if (phase_en || phase == PH_A) begin
			scl_drive <= next_scl_drive;
			sda_drive <= next_sda_drive;
		end
	end

	// Open drain: output level is always low, only the enable toggles
	assign O_SCL    = 1'b0;
	assign O_SDA    = 1'b0;
	assign O_SCL_OE = scl_drive;
	assign O_SDA_OE = sda_drive;

	// ======================================================================
	// Byte sequencer
	byte_state_t bstate;
	logic [7:0]  shifter;
	logic [2:0]  bit_cnt;
	logic        owner;

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			bstate  <= BY_IDLE;
			shifter <= 8'h00;
			bit_cnt <= 3'h0;
			bit_go  <= 1'b0;
			bit_op  <= OP_START;
			bit_din <= 1'b1;
			finish  <= 1'b0;
			rx_data <= 8'h00;
			rx_nack <= 1'b0;
			owner   <= 1'b0;
		end else begin
			bit_go <= 1'b0;
			finish <= 1'b0;
			if (lost) begin
				bstate <= BY_IDLE;
				owner  <= 1'b0;
			end else begin
				case (bstate)
					BY_IDLE: begin
						if (xfer_busy && !finish && !bit_go) begin
							if (cmd_begin) begin
								// Idle bus, or ours already for repeat
								if (!bus_busy || owner) begin
									bit_go <= 1'b1;
									bit_op <= OP_START;
									owner  <= 1'b1;
									bstate <= BY_START;
								end
							end else if (cmd_read || cmd_write) begin
								shifter <= tx_hold;
								bit_cnt <= 3'h7;
								bit_go  <= 1'b1;
								bit_op  <= cmd_read ? OP_READ : OP_WRITE;
								bit_din <= tx_hold[7];
								bstate  <= BY_DATA;
							end else begin
								bit_go <= 1'b1;
								bit_op <= OP_STOP;
								bstate <= BY_STOP;
							end
						end
					end
					BY_START: begin
						if (bit_done) begin
							// Address goes out as a plain data byte
							shifter <= tx_hold;
							bit_cnt <= 3'h7;
							bit_go  <= 1'b1;
							bit_op  <= cmd_read ? OP_READ : OP_WRITE;
							bit_din <= tx_hold[7];
							bstate  <= BY_DATA;
						end
					end
					BY_DATA: begin
						if (bit_done) begin
							shifter <= {shifter[6:0], bit_out};
							bit_go  <= 1'b1;
							if (bit_cnt == 3'h0) begin
								// Reader acks, writer listens
								bit_op  <= cmd_read ? OP_WRITE : OP_READ;
								bit_din <= cmd_nack;
								bstate  <= BY_ACK;
							end else begin
								bit_cnt <= bit_cnt - 3'h1;
								bit_din <= shifter[6];
							end
						end
					end
					BY_ACK: begin
						if (bit_done) begin
							if (cmd_read) begin
								rx_data <= shifter;
							end else begin
								rx_nack <= bit_out;
							end
							if (cmd_stop) begin
								bit_go <= 1'b1;
								bit_op <= OP_STOP;
								bstate <= BY_STOP;
							end else begin
								finish <= 1'b1;
								bstate <= BY_IDLE;
							end
						end
					end
					BY_STOP: begin
						if (bit_done) begin
							owner  <= 1'b0;
							finish <= 1'b1;
							bstate <= BY_IDLE;
						end
					end
					default: bstate <= BY_IDLE;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// File: shared/i2c_byte_engine_map.svh
`ifndef I2C_BYTE_ENGINE_MAP_SVH
`define I2C_BYTE_ENGINE_MAP_SVH

// ==========================================================================
// Register offsets (3-bit address, 8-bit data)
`define REG_PRESC_LO     3'h0
`define REG_PRESC_HI     3'h1
`define REG_CTRL         3'h2
`define REG_DATA         3'h3
`define REG_CMD_STAT     3'h4

// ==========================================================================
// Control register fields
`define CTRL_EN_BIT      7
`define CTRL_IEN_BIT     6

// Command register fields (write side of REG_CMD_STAT)
`define CMD_BEGIN_BIT    7
`define CMD_STOP_BIT     6
`define CMD_READ_BIT     5
`define CMD_WRITE_BIT    4
`define CMD_NACK_BIT     3
`define CMD_IACK_BIT     0

// Status register fields (read side of REG_CMD_STAT)
`define STAT_RXNACK_BIT  7
`define STAT_BUSY_BIT    6
`define STAT_ARBLOST_BIT 5
`define STAT_XFER_BIT    1
`define STAT_DONE_BIT    0

// ==========================================================================
// Reset values
`define CTRL_RESET       8'h00
`define DATA_RESET       8'h00

// ==========================================================================
// Timing: prescaler gives an enable at four times the bus rate
`define SYS_CLK_HZ       50000000
`define SCL_STD_HZ       100000
`define SCL_FAST_HZ      400000
`define PHASES_PER_BIT   4
`define PRESC_STD        ((`SYS_CLK_HZ / (`PHASES_PER_BIT * `SCL_STD_HZ)) - 1)
`define PRESC_FAST       ((`SYS_CLK_HZ / (`PHASES_PER_BIT * `SCL_FAST_HZ)) - 1)

`endif

// File: shared/i2c_byte_engine_pkg.sv
package i2c_byte_engine_pkg;

	// Sampled state of the two bus lines
	typedef struct packed {
		logic scl;
		logic sda;
	} line_pair_t;

	// Operation handed to the bit sequencer
	typedef enum logic [1:0] {
		OP_START,
		OP_STOP,
		OP_WRITE,
		OP_READ
	} bit_op_t;

	// Phases of one bit operation
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_A,
		PH_B,
		PH_C,
		PH_D
	} bit_phase_t;

	// Byte sequencer states
	typedef enum logic [2:0] {
		BY_IDLE,
		BY_START,
		BY_DATA,
		BY_ACK,
		BY_STOP
	} byte_state_t;

endpackage

// File: sim/i2c_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Serial slave with a single address
module i2c_slave_model #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	// Wired lines
	input  wire logic       scl,
	input  wire logic       sda,
	// Bench controls
	input  wire logic       stretch,
	input  wire logic [7:0] tx_byte,
	// Pull-low enables and results
	output logic            sda_oe,
	output logic            scl_oe,
	output logic [7:0]      rx_byte,
	output logic            got_stop
);
	logic [7:0] sh;
	logic       active, first, sel, rw, ack, rdg;
	int         cnt;
	initial begin
		{sda_oe, scl_oe, active, got_stop, rdg} = 5'b00000;
		rx_byte = 8'h00;
		cnt = 0;
	end
	always @(negedge sda) if (scl) begin
		{active, first, got_stop, sel, rdg, sda_oe} = 6'b110000;
		cnt = 0;
	end
	always @(posedge sda) if (scl) begin
		{active, got_stop, sda_oe} = 3'b010;
	end
	always @(posedge scl) if (active) begin
		if (cnt < 8) sh = {sh[6:0], sda};
		else ack = sda;
		cnt++;
	end
	// Lines change only with the clock low; a nack ends our drive
	always @(negedge scl) if (active) begin
		if (cnt == 8) begin
			if (first) {sel, rw} = {sh[7:1] == ADDR, sh[0]};
			else if (sel && !rw) rx_byte = sh;
			sda_oe = sel && (first || !rw);
		end else if (cnt == 9) begin
			rdg = sel && rw && (first || !ack);
			first = 1'b0;
			cnt = 0;
			sda_oe = rdg && !tx_byte[7];
		end else sda_oe = rdg && !tx_byte[7 - cnt];
		if (stretch) begin
			scl_oe = 1'b1;
			#400 scl_oe = 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: sim/i2c_master_byte_engine_props.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Port checks of the byte engine
module i2c_engine_props (
	input wire logic       I_CLK,
	input wire logic       I_RST,
	input wire logic [2:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic       I_WR,
	input wire logic       I_RD,
	input wire logic [7:0] O_RDATA,
	input wire logic       O_IRQ,
	input wire logic       I_SCL,
	input wire logic       O_SCL,
	input wire logic       O_SCL_OE,
	input wire logic       I_SDA,
	input wire logic       O_SDA,
	input wire logic       O_SDA_OE
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	open_drain_a: assert property (!O_SCL && !O_SDA)
		else $error("line driven high");
	rdata_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
		else $error("read data outside its slot");
	unmapped_rd_a: assert property (I_RD && I_ADDR > 3'h4 |=> O_RDATA == 8'h00)
		else $error("unmapped read not zero");
	presc_back_a: assert property (I_WR && I_ADDR == 3'h0 ##1
		I_RD && I_ADDR == 3'h0 |=> O_RDATA == $past(I_WDATA, 2))
		else $error("prescale readback wrong");
	irq_done_a: assert property (I_RD && I_ADDR == 3'h4 && O_IRQ |=> O_RDATA[0])
		else $error("irq without done");
	irq_clear_a: assert property (I_WR && I_ADDR == 3'h4 && I_WDATA == 8'h01
		|=> ##1 !O_IRQ)
		else $error("irq not cleared");
	clk_low_a: assert property ($rose(O_SCL_OE) |=> O_SCL_OE)
		else $error("clock low phase too short");
	clk_high_a: assert property ($fell(O_SCL_OE) |=> !O_SCL_OE)
		else $error("clock high phase too short");
	// Slow sync means only long stretches are judged
	stretch_wait_a: assert property ((!O_SCL_OE && !I_SCL) [*3]
		|=> !O_SCL_OE && $stable(O_SDA_OE))
		else $error("moved during stretch");
	start_hold_a: assert property ($rose(O_SDA_OE) && I_SCL && !O_SCL_OE
		|=> !O_SCL_OE && O_SDA_OE)
		else $error("start not held");
	stop_hold_a: assert property ($fell(O_SDA_OE) && I_SCL && !O_SCL_OE
		|=> !O_SDA_OE)
		else $error("stop not held");
	cover property ($rose(O_SDA_OE) && I_SCL && !O_SCL_OE);
	cover property ((!O_SCL_OE && !I_SCL) [*3]);
	cover property ($rose(O_IRQ));
endmodule
`default_nettype wire

// File: sim/test_i2c_master_byte_engine.sv
`timescale 1ns/10ps
`default_nettype none
`include "i2c_byte_engine_map.svh"
// ==========
// Bench top
module test_i2c_master_byte_engine;
	localparam logic [6:0] SLV = 7'h2a;
	logic       clk, rst, wr, rd, stretch, tb_sda_oe, irq, got_stop;
	logic       scl_o, scl_oe, sda_o, sda_oe, s_sda_oe, s_scl_oe;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, tx_byte, rx_byte, st, v, d;
	wire        scl_w;
	wire        sda_w;
	int         miscompares, n_checks, tn, i, k;
	// Pull-ups make each line the AND of all drivers
	assign scl_w = ~((scl_oe & ~scl_o) | s_scl_oe);
	assign sda_w = ~((sda_oe & ~sda_o) | s_sda_oe | tb_sda_oe);
	i2c_master_byte_engine dut_u (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr),
		.I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq),
		.I_SCL(scl_w), .O_SCL(scl_o), .O_SCL_OE(scl_oe), .I_SDA(sda_w),
		.O_SDA(sda_o), .O_SDA_OE(sda_oe));
	i2c_slave_model #(.ADDR(SLV)) slv_u (.scl(scl_w), .sda(sda_w),
		.stretch(stretch), .tx_byte(tx_byte), .sda_oe(s_sda_oe),
		.scl_oe(s_scl_oe), .rx_byte(rx_byte), .got_stop(got_stop));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ==========
	// Tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic done_test();
		$display("test %0d finished", tn);
		tn++;
	endtask
	// A write leaves its strobe up; the next read releases it
	task automatic reg_wr(input logic [2:0] a, input logic [7:0] x);
		@(posedge clk);
		addr <= a;
		wdata <= x;
		wr <= 1'b1;
	endtask
	task automatic reg_rd(input logic [2:0] a, output logic [7:0] x);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		wr <= 1'b0;
		@(posedge clk);
		rd <= 1'b0;
		#1 x = rdata;
	endtask
	task automatic wait_done(output logic [7:0] s);
		int  n;
		logic seen_xfer;
		seen_xfer = 1'b0;
		for (n = 0; n < 3000; n++) begin
			reg_rd(`REG_CMD_STAT, s);
			if (s[`STAT_XFER_BIT] === 1'b1) seen_xfer = 1'b1;
			if (s[`STAT_DONE_BIT] === 1'b1 && s[`STAT_XFER_BIT] === 1'b0) break;
		end
		check({7'h0, seen_xfer}, 8'h01);
		if (n == 3000) begin
			miscompares++;
			tally_and_finish();
		end
	endtask
	task automatic cmd(input logic [7:0] c, output logic [7:0] s);
		reg_wr(`REG_CMD_STAT, c | 8'h01);
		wait_done(s);
	endtask
	function automatic logic [7:0] exp_stat(input logic nack, input logic lost);
		exp_stat = 8'h01;
		exp_stat[`STAT_RXNACK_BIT] = nack;
		exp_stat[`STAT_ARBLOST_BIT] = lost;
	endfunction
	// ==========
	// Main sequence
	initial begin
		{rst, wr, rd, stretch, tb_sda_oe} = 5'b10000;
		addr = 3'h0;
		wdata = 8'h00;
		tx_byte = 8'h00;
		{miscompares, n_checks, tn} = 96'h0;
		void'($urandom(49));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		check({7'h0, irq}, 8'h00);
		reg_rd(`REG_CTRL, v);
		check(v, `CTRL_RESET);
		reg_rd(`REG_PRESC_LO, v);
		check(v, 8'(`PRESC_STD));
		reg_rd(`REG_CMD_STAT, v);
		check(v, 8'h00);
		reg_wr(3'h5, 8'h5a);
		reg_rd(3'h5, v);
		check(v, 8'h00);
		done_test();
		// Prescale 1 gives a 160 ns bus clock
		reg_wr(`REG_PRESC_LO, 8'h01);
		reg_rd(`REG_PRESC_LO, v);
		check(v, 8'h01);
		reg_wr(`REG_PRESC_HI, 8'h00);
		reg_wr(`REG_CTRL, 8'hc0);
		reg_rd(`REG_CTRL, v);
		check(v & 8'hc0, 8'hc0);
		done_test();
		for (i = 0; i < 3; i++) begin
			d = 8'($urandom);
			tx_byte = 8'($urandom);
			stretch = i[0];
			reg_wr(`REG_DATA, {SLV, 1'b0});
			cmd(8'h90, st);
			check(st & 8'he3, exp_stat(1'b0, 1'b0) | 8'h40);
			check({7'h0, irq}, 8'h01);
			reg_wr(`REG_DATA, d);
			cmd(8'h10, st);
			check(st & 8'ha3, exp_stat(1'b0, 1'b0));
			check(rx_byte, d);
			reg_wr(`REG_DATA, {SLV, 1'b1});
			cmd(8'h90, st);
			check(st & 8'ha3, exp_stat(1'b0, 1'b0));
			cmd(8'h68, st);
			reg_rd(`REG_DATA, v);
			check(v, tx_byte);
			reg_rd(`REG_CMD_STAT, st);
			check(st & 8'h63, exp_stat(1'b0, 1'b0));
			check({7'h0, got_stop}, 8'h01);
		end
		done_test();
		reg_wr(`REG_DATA, {SLV ^ 7'h01, 1'b0});
		cmd(8'hd0, st);
		check(st & 8'ha3, exp_stat(1'b1, 1'b0));
		reg_wr(`REG_CTRL, 8'h80);
		reg_rd(`REG_CTRL, v);
		check({7'h0, irq}, 8'h00);
		reg_wr(`REG_CTRL, 8'hc0);
		reg_rd(`REG_CTRL, v);
		check({7'h0, irq}, 8'h01);
		reg_wr(`REG_CMD_STAT, 8'h01);
		reg_rd(`REG_CMD_STAT, v);
		check({5'h00, v[1:0], irq}, 8'h00);
		done_test();
		@(posedge clk);
		tb_sda_oe <= 1'b1;
		reg_rd(`REG_CMD_STAT, st);
		reg_rd(`REG_CMD_STAT, st);
		check(st & 8'h40, 8'h40);
		reg_wr(`REG_DATA, {SLV, 1'b0});
		reg_wr(`REG_CMD_STAT, 8'hd1);
		for (k = 0; k < 8; k++) begin
			reg_rd(`REG_CMD_STAT, st);
			check({scl_oe, sda_oe}, 2'h0);
		end
		@(posedge clk);
		tb_sda_oe <= 1'b0;
		wait_done(st);
		check(st & 8'ha3, exp_stat(1'b0, 1'b0));
		done_test();
		reg_wr(`REG_DATA, 8'hff);
		reg_wr(`REG_CMD_STAT, 8'h91);
		reg_rd(`REG_CMD_STAT, st);
		for (k = 0; k < 200 && scl_w; k++) @(posedge clk);
		tb_sda_oe <= 1'b1;
		wait_done(st);
		check(st & 8'h23, exp_stat(1'b0, 1'b1));
		check({scl_oe, sda_oe}, 2'h0);
		@(posedge clk);
		tb_sda_oe <= 1'b0;
		done_test();
		tally_and_finish();
	end
endmodule
bind i2c_master_byte_engine i2c_engine_props chk_u (.I_CLK(I_CLK),
	.I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
	.I_RD(I_RD), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ), .I_SCL(I_SCL),
	.O_SCL(O_SCL), .O_SCL_OE(O_SCL_OE), .I_SDA(I_SDA), .O_SDA(O_SDA),
	.O_SDA_OE(O_SDA_OE));
`default_nettype wire
